// *** sdp_pkg.sv ***
package sdp_pkg;
	localparam int LANE_W = 9;
	localparam int MAX_LANES = 4;
	localparam int DW_X9 = 9;
	localparam int DW_X18 = 18;
	localparam int DW_X36 = 36;
	localparam int AW_X9 = 23;
	localparam int AW_X18 = 22;
	localparam int AW_X36 = 21;
	localparam int CTRL_PINS = 7;
	localparam logic RST_LVL = 1'b0;

	// Read output sequencer, Gray coded along idle -> beat0 -> beat1
	typedef enum logic [1:0] {
		SDP_OUT_IDLE = 2'b00,
		SDP_OUT_BEAT0 = 2'b01,
		SDP_OUT_BEAT1 = 2'b11
	} sdp_out_e;

	function automatic int sdp_addr_w(input int dw);
		int aw;
		aw = 0;
		if (dw == DW_X9) begin
			aw = AW_X9;
		end else if (dw == DW_X18) begin
			aw = AW_X18;
		end else if (dw == DW_X36) begin
			aw = AW_X36;
		end
		return aw;
	endfunction
endpackage

// *** sdp_sync.sv ***
`timescale 1ns/1ps
module sdp_sync #(
	parameter int W = 1
) (
	input wire logic ref_clk_i,
	input wire logic arst_n_i,
	input wire logic [W-1:0] async_i,
	output logic [W-1:0] sync_o
);
	logic [W-1:0] meta_r;

	// First stage is read by the second stage only
	always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			meta_r <= '0;
			sync_o <= '0;
		end else begin
			meta_r <= async_i;
			sync_o <= meta_r;
		end
	end
endmodule

// *** sdp_sram_pins.sv ***
`timescale 1ns/1ps
// Operation
// - write data taken on both main rises
// - low write select at main rise starts write
// - deselected write port ignores data inputs
// - byte lane selects gate each beat's bytes
// - read address on pos, write on neg
// - address width 23/22/21, two half arrays
// - address ignored while port deselected
// - low read select at main rise starts read
// - finish read, then release after output rise
// - every read returns exactly two beats
// - read data launched by output clock pair
// - accesses start only on main positive rise
// - main clocks capture; launch in single mode
// - free-running echo clocks follow launching pair
module sdp_sram_pins
	import sdp_pkg::*;
#(
	parameter int DATA_W = DW_X18,
	parameter int ADDR_W = sdp_addr_w(DATA_W),
	parameter int MEM_AW = ADDR_W
) (
	input wire logic ref_clk_i,
	input wire logic arst_n_i,
	input wire logic main_clk_i,
	input wire logic main_clk_n_i,
	input wire logic out_clk_i,
	input wire logic out_clk_n_i,
	input wire logic single_clk_mode_i,
	input wire logic write_port_sel_n_i,
	input wire logic read_port_sel_n_i,
	input wire logic [DATA_W/LANE_W-1:0] byte_lane_sel_n_i,
	input wire logic [ADDR_W-1:0] addr_i,
	input wire logic [DATA_W-1:0] wdata_i,
	output logic [DATA_W-1:0] rdata_o,
	output logic rdata_oe_o,
	output logic echo_strobe_pos_o,
	output logic echo_strobe_neg_o
);
	localparam int LANES = DATA_W / LANE_W;
	localparam int SW = CTRL_PINS + LANES + ADDR_W + DATA_W;

	generate
		if (sdp_addr_w(DATA_W) == 0 || ADDR_W != sdp_addr_w(DATA_W)) begin : g_bad_org
			$error("Data width must be 9, 18 or 36 with matching address width");
		end
		if (MEM_AW < 1 || MEM_AW > ADDR_W) begin : g_bad_mem
			$error("MEM_AW must lie between 1 and ADDR_W");
		end
	endgenerate

	// Every pin arrives from outside this clock domain
	logic [SW-1:0] pins_s;

	sdp_sync #(
		.W(SW)
	) u_sync (
		.ref_clk_i(ref_clk_i),
		.arst_n_i(arst_n_i),
		.async_i({main_clk_i, main_clk_n_i, out_clk_i, out_clk_n_i,
			single_clk_mode_i, write_port_sel_n_i, read_port_sel_n_i,
			byte_lane_sel_n_i, addr_i, wdata_i}),
		.sync_o(pins_s)
	);

	wire k_s = pins_s[SW-1];
	wire kn_s = pins_s[SW-2];
	wire c_s = pins_s[SW-3];
	wire cn_s = pins_s[SW-4];
	wire single_s = pins_s[SW-5];
	wire wsel_n_s = pins_s[SW-6];
	wire rsel_n_s = pins_s[SW-7];
	wire [LANES-1:0] lane_n_s = pins_s[ADDR_W+DATA_W+:LANES];
	wire [ADDR_W-1:0] addr_s = pins_s[DATA_W+:ADDR_W];
	wire [DATA_W-1:0] wdata_s = pins_s[DATA_W-1:0];

	// Launching pair: output clocks, or main clocks in single clock mode
	wire opos_s = single_s ? k_s : c_s;
	wire oneg_s = single_s ? kn_s : cn_s;

	logic k_d_r;
	logic kn_d_r;
	logic opos_d_r;
	logic oneg_d_r;

	always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			k_d_r <= RST_LVL;
			kn_d_r <= RST_LVL;
			opos_d_r <= RST_LVL;
			oneg_d_r <= RST_LVL;
		end else begin
			k_d_r <= k_s;
			kn_d_r <= kn_s;
			opos_d_r <= opos_s;
			oneg_d_r <= oneg_s;
		end
	end

	wire k_rise = k_s & ~k_d_r;
	wire kn_rise = kn_s & ~kn_d_r;
	wire opos_rise = opos_s & ~opos_d_r;
	wire oneg_rise = oneg_s & ~oneg_d_r;

	// Accesses begin only on main positive rises
	wire wr_start = k_rise & ~wsel_n_s;
	wire rd_start = k_rise & ~rsel_n_s;

	// Two half-depth arrays: beat0 and beat1 of each burst
	logic [DATA_W-1:0] mem0 [2**MEM_AW];
	logic [DATA_W-1:0] mem1 [2**MEM_AW];

	// Write side
	logic wr_pend_r;
	logic [DATA_W-1:0] wr_beat0_r;
	logic [LANES-1:0] wr_lane0_n_r;

	always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			wr_pend_r <= 1'b0;
			wr_beat0_r <= '0;
			wr_lane0_n_r <= '1;
		end else if (k_rise) begin
			wr_pend_r <= ~wsel_n_s;
			if (wr_start) begin
				wr_beat0_r <= wdata_s;
				wr_lane0_n_r <= lane_n_s;
			end
		end else if (kn_rise) begin
			wr_pend_r <= 1'b0;
		end
	end

	// Second beat and write address arrive with the negative rise
	wire wr_go = kn_rise & wr_pend_r;
	wire [MEM_AW-1:0] waddr = addr_s[MEM_AW-1:0];

	// One process writes both arrays so each has a single driver
	always_ff @(posedge ref_clk_i) begin
		for (int gl = 0; gl < LANES; gl++) begin
			if (wr_go && !wr_lane0_n_r[gl]) begin
				mem0[waddr][gl*LANE_W+:LANE_W] <=
					wr_beat0_r[gl*LANE_W+:LANE_W];
			end
			if (wr_go && !lane_n_s[gl]) begin
				mem1[waddr][gl*LANE_W+:LANE_W] <=
					wdata_s[gl*LANE_W+:LANE_W];
			end
		end
	end

	// Read side
	wire [MEM_AW-1:0] raddr = addr_s[MEM_AW-1:0];
	logic rd_pend_r;
	logic [DATA_W-1:0] rd_buf0_r;
	logic [DATA_W-1:0] rd_buf1_r;
	logic [DATA_W-1:0] rd_beat1_r;
	sdp_out_e out_st_r;
	sdp_out_e out_st_nxt;

	always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			rd_buf0_r <= '0;
			rd_buf1_r <= '0;
		end else if (rd_start) begin
			rd_buf0_r <= mem0[raddr];
			rd_buf1_r <= mem1[raddr];
		end
	end

	// A read taken in the same cycle as a launch stays pending
	wire launch = opos_rise & rd_pend_r;

	always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			rd_pend_r <= 1'b0;
		end else if (rd_start) begin
			rd_pend_r <= 1'b1;
		end else if (launch) begin
			rd_pend_r <= 1'b0;
		end
	end

	always_comb begin
		out_st_nxt = out_st_r;
		case (out_st_r)
			SDP_OUT_IDLE: begin
				if (launch) begin
					out_st_nxt = SDP_OUT_BEAT0;
				end
			end
			SDP_OUT_BEAT0: begin
				if (oneg_rise) begin
					out_st_nxt = SDP_OUT_BEAT1;
				end
			end
			SDP_OUT_BEAT1: begin
				if (launch) begin
					out_st_nxt = SDP_OUT_BEAT0;
				end else if (opos_rise) begin
					out_st_nxt = SDP_OUT_IDLE;
				end
			end
			default: begin
				out_st_nxt = SDP_OUT_IDLE;
			end
		endcase
	end

	wire drive_beat0 = launch & (out_st_r != SDP_OUT_BEAT0);
	wire drive_beat1 = oneg_rise & (out_st_r == SDP_OUT_BEAT0);

	always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			out_st_r <= SDP_OUT_IDLE;
			rd_beat1_r <= '0;
			rdata_o <= '0;
			rdata_oe_o <= 1'b0;
		end else begin
			out_st_r <= out_st_nxt;
			if (drive_beat0) begin
				rdata_o <= rd_buf0_r;
				rd_beat1_r <= rd_buf1_r;
				rdata_oe_o <= 1'b1;
			end else if (drive_beat1) begin
				rdata_o <= rd_beat1_r;
			end else if (opos_rise && out_st_r == SDP_OUT_BEAT1) begin
				rdata_oe_o <= 1'b0;
			end
		end
	end

	// Echo clocks run free and follow the launching pair
	always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			echo_strobe_pos_o <= RST_LVL;
			echo_strobe_neg_o <= RST_LVL;
		end else begin
			echo_strobe_pos_o <= opos_s;
			echo_strobe_neg_o <= oneg_s;
		end
	end
endmodule

// *** sdp_sram_pins_assertions.sv ***
`timescale 1ns/1ps
module sdp_sram_pins_chk
	import sdp_pkg::*;
#(
	parameter int DATA_W = DW_X18
) (
	input wire logic ref_clk_i,
	input wire logic arst_n_i,
	input wire logic main_clk_i,
	input wire logic out_clk_i,
	input wire logic out_clk_n_i,
	input wire logic read_port_sel_n_i,
	input wire logic [DATA_W-1:0] rdata_o,
	input wire logic rdata_oe_o,
	input wire logic echo_strobe_pos_o,
	input wire logic echo_strobe_neg_o
);
	default clocking @(posedge ref_clk_i); endclocking
	default disable iff (!arst_n_i);
	sequence rd_rise;
		$rose(main_clk_i) && !read_port_sel_n_i;
	endsequence
	sequence idle_rise;
		$rose(main_clk_i) && read_port_sel_n_i;
	endsequence
	a_echo_pos_rise: assert property
		($rose(out_clk_i) |-> ##[2:4] echo_strobe_pos_o) else $error("echo");
	a_echo_pos_fall: assert property
		($fell(out_clk_i) |-> ##[2:4] !echo_strobe_pos_o) else $error("echo");
	a_echo_neg_rise: assert property
		($rose(out_clk_n_i) |-> ##[2:4] echo_strobe_neg_o) else $error("echo");
	a_data_on_edge: assert property
		($changed(rdata_o) |-> $past(out_clk_i, 3) != $past(out_clk_i, 6))
		else $error("data");
	a_oe_on_pos: assert property
		($rose(rdata_oe_o) |-> $past(out_clk_i, 3) && !$past(out_clk_i, 6))
		else $error("oe");
	a_read_gives_oe: assert property
		(rd_rise |-> ##[1:20] rdata_oe_o) else $error("oe");
	a_burst_holds: assert property
		($rose(rdata_oe_o) |-> rdata_oe_o [*8]) else $error("oe");
	a_idle_release: assert property
		(idle_rise ##[10:20] idle_rise |-> !rdata_oe_o) else $error("oe");
endmodule
bind sdp_sram_pins sdp_sram_pins_chk #(.DATA_W(DATA_W)) u_chk (.ref_clk_i,
	.arst_n_i, .main_clk_i, .out_clk_i, .out_clk_n_i, .read_port_sel_n_i,
	.rdata_o, .rdata_oe_o, .echo_strobe_pos_o, .echo_strobe_neg_o);

// *** sdp_ctrl_model.sv ***
`timescale 1ns/1ps
module sdp_ctrl_model
	import sdp_pkg::*;
#(
	parameter int DW = DW_X18,
	parameter int AW = AW_X18
) (
	input wire logic ref_clk_i,
	output logic mk_o,
	output logic mkn_o,
	output logic ck_o,
	output logic ckn_o,
	output logic ws_n_o,
	output logic rs_n_o,
	output logic [1:0] bl_n_o,
	output logic [AW-1:0] a_o,
	output logic [DW-1:0] d_o
);
	initial begin
		{mk_o, ck_o, ws_n_o, rs_n_o, mkn_o, ckn_o} = 6'h0f;
		bl_n_o = '1;
		a_o = '0;
		d_o = '0;
	end
	task automatic tk(input int n);
		repeat (n) @(negedge ref_clk_i);
	endtask
	task automatic access(input logic wr, input logic rd,
		input logic [AW-1:0] ra, input logic [AW-1:0] wa,
		input logic [DW-1:0] d0, input logic [DW-1:0] d1,
		input logic [1:0] l0, input logic [1:0] l1);
		ws_n_o = !wr;
		rs_n_o = !rd;
		a_o = rd ? ra : ~a_o;
		d_o = wr ? d0 : ~d_o;
		bl_n_o = l0;
		tk(4);
		mk_o = 1'b1;
		mkn_o = 1'b0;
		tk(2);
		ck_o = 1'b1;
		ckn_o = 1'b0;
		tk(2);
		a_o = wr ? wa : ~a_o;
		d_o = wr ? d1 : ~d_o;
		bl_n_o = l1;
		tk(4);
		mk_o = 1'b0;
		mkn_o = 1'b1;
		tk(2);
		ck_o = 1'b0;
		ckn_o = 1'b1;
		tk(2);
	endtask
endmodule

// *** tb_sep_port_ddr_sram_pins.sv ***
`timescale 1ns/1ps
`define CHK(n, e, g) begin n_tests++; if ((g) !== (e)) begin num_errors++; \
	$display("[ERR] %s exp %h got %h", n, e, g); end end
module tb_sep_port_ddr_sram_pins;
	import sdp_pkg::*;
	localparam int DW = DW_X18;
	localparam int AW = AW_X18;
	logic ref_clk_i = 1'b0;
	logic arst_n_i = 1'b0;
	logic single_clk_mode_i = 1'b0;
	logic main_clk_i, main_clk_n_i, out_clk_i, out_clk_n_i, rd_prev = 1'b0;
	logic write_port_sel_n_i, read_port_sel_n_i;
	logic [1:0] byte_lane_sel_n_i;
	logic [AW-1:0] addr_i;
	logic [DW-1:0] wdata_i, rdata_o, e1;
	logic rdata_oe_o, echo_strobe_pos_o, echo_strobe_neg_o;
	logic [DW-1:0] m0 [16];
	logic [DW-1:0] m1 [16];
	int num_errors = 0;
	int n_tests = 0;
	int cyc = 0;
	always #4 ref_clk_i = ~ref_clk_i;
	sdp_ctrl_model ctl (.ref_clk_i, .mk_o(main_clk_i), .mkn_o(main_clk_n_i),
		.ck_o(out_clk_i), .ckn_o(out_clk_n_i), .ws_n_o(write_port_sel_n_i),
		.rs_n_o(read_port_sel_n_i), .bl_n_o(byte_lane_sel_n_i),
		.a_o(addr_i), .d_o(wdata_i));
	sdp_sram_pins #(.MEM_AW(4)) uut (.ref_clk_i, .arst_n_i, .main_clk_i,
		.main_clk_n_i, .out_clk_i, .out_clk_n_i, .single_clk_mode_i,
		.write_port_sel_n_i, .read_port_sel_n_i, .byte_lane_sel_n_i, .addr_i,
		.wdata_i, .rdata_o, .rdata_oe_o, .echo_strobe_pos_o, .echo_strobe_neg_o);
	function automatic logic [DW-1:0] mrg(logic [DW-1:0] o, logic [DW-1:0] n,
		logic [1:0] l);
		return {l[1] ? o[17:9] : n[17:9], l[0] ? o[8:0] : n[8:0]};
	endfunction
	task automatic wrap_up();
		$display("errors %0d checks %0d", num_errors, n_tests);
		if (num_errors == 0 && n_tests > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	always @(posedge ref_clk_i) begin
		cyc <= cyc + 1;
		if (cyc == 3000) begin
			num_errors++;
			wrap_up();
		end
	end
	task automatic op(input logic wr, input logic rd, input logic [AW-1:0] wa,
		input logic [1:0] l0, input logic [1:0] l1);
		logic [AW-1:0] ra;
		logic [DW-1:0] d0, d1;
		ra = AW'($urandom);
		d0 = DW'($urandom);
		d1 = DW'($urandom);
		fork
			ctl.access(wr, rd, ra, wa, d0, d1, l0, l1);
			begin
				repeat (4) @(negedge ref_clk_i);
				if (rd_prev) `CHK("beat1", e1, rdata_o)
				e1 = m1[ra[3:0]];
				repeat (8) @(negedge ref_clk_i);
				`CHK("oe", rd, rdata_oe_o)
				if (rd) `CHK("beat0", m0[ra[3:0]], rdata_o)
			end
		join
		if (wr) begin
			m0[wa[3:0]] = mrg(m0[wa[3:0]], d0, l0);
			m1[wa[3:0]] = mrg(m1[wa[3:0]], d1, l1);
		end
		rd_prev = rd;
	endtask
	initial begin
		void'($urandom(32'h13b1));
		repeat (5) @(negedge ref_clk_i);
		arst_n_i = 1'b1;
		repeat (4) @(negedge ref_clk_i);
		for (int i = 0; i < 16; i++)
			op(1'b1, 1'b0, AW'(i), 2'b00, 2'b00);
		op(1'b1, 1'b1, '0, 2'b11, 2'b10);
		for (int i = 0; i < 40; i++)
			op(1'($urandom), 1'($urandom), AW'($urandom), 2'($urandom),
				2'($urandom));
		op(1'b0, 1'b0, '0, 2'b00, 2'b00);
		op(1'b0, 1'b0, '0, 2'b00, 2'b00);
		// Single clock mode: echoes follow the main pair, not the output pair
		single_clk_mode_i = 1'b1;
		repeat (4) @(negedge ref_clk_i);
		fork
			ctl.access(1'b0, 1'b0, '0, '0, '0, '0, 2'b11, 2'b11);
			begin
				repeat (8) @(negedge ref_clk_i);
				`CHK("echo_pos", 1'b1, echo_strobe_pos_o)
				`CHK("echo_neg", 1'b0, echo_strobe_neg_o)
			end
		join
		wrap_up();
	end
endmodule
